// ==== rtl/status_led_blink_coder.sv ====
// node status indicator driver: bus activity, start-up flash and fault blink code
`timescale 1ns/1ps
`default_nettype none
module status_led_blink_coder #(
  parameter int unsigned FAST_HALF = status_led_pkg::FAST_HALF,
  parameter int unsigned SLOW_HALF = status_led_pkg::SLOW_HALF,
  parameter int unsigned PAUSE_CYC = status_led_pkg::PAUSE_CYC
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic bus_cycle,
  input wire logic init_busy,
  input wire logic fault_valid,
  input wire logic [3:0] fault_code,
  input wire logic [3:0] fault_arg,
  output logic led_red,
  output logic led_green
);
  localparam logic [27:0] FAST_T = 28'(FAST_HALF - 1);
  localparam logic [27:0] SLOW_T = 28'(SLOW_HALF - 1);
  localparam logic [27:0] PAUSE_T = 28'(PAUSE_CYC - 1);
  localparam logic [4:0] BURST_N = 5'(status_led_pkg::START_PULSES);

  // ----------------------------------------
  // state
  // ----------------------------------------
  status_led_pkg::blink_state_e state, next_state, after_pause, next_after_pause;
  logic [27:0] timer, next_timer;
  logic [4:0] pulses, next_pulses;
  logic phase_on, next_phase_on;
  logic held, next_held;
  logic [3:0] code_q, next_code_q;
  logic [3:0] arg_q, next_arg_q;
  logic next_led_red, next_led_green;
  logic timer_done;
  logic [4:0] group_len;

  assign timer_done = (timer == 28'h0000000);

  // pulses wanted in the group now showing; a zero value still shows one
  // pulse, so that the group can never vanish into the pauses around it
  always_comb begin
    group_len = 5'h01;
    if (state == status_led_pkg::ST_BURST) begin
      group_len = BURST_N;
    end else if ((state == status_led_pkg::ST_CODE) && (code_q != 4'h0)) begin
      group_len = {1'b0, code_q};
    end else if ((state == status_led_pkg::ST_ARG) && (arg_q != 4'h0)) begin
      group_len = {1'b0, arg_q};
    end
  end

  // ----------------------------------------
  // sequencer
  // ----------------------------------------
  always_comb begin
    next_state = state;
    next_after_pause = after_pause;
    next_timer = timer_done ? 28'h0000000 : timer - 28'h0000001;
    next_pulses = pulses;
    next_phase_on = phase_on;
    next_held = held;
    next_code_q = code_q;
    next_arg_q = arg_q;
    // first fault report is latched; later reports ignored until reset
    if (fault_valid && !held) begin
      next_held = 1'b1;
      next_code_q = fault_code;
      next_arg_q = fault_arg;
    end
    unique case (state)
      status_led_pkg::ST_INIT: begin
        if (timer_done) begin
          next_phase_on = !phase_on;
          next_timer = FAST_T;
        end
        if (!init_busy) begin
          if (held || fault_valid) begin
            next_state = status_led_pkg::ST_PAUSE;
            next_after_pause = status_led_pkg::ST_BURST;
            next_timer = PAUSE_T;
            next_phase_on = 1'b0;
          end else begin
            next_state = status_led_pkg::ST_RUN;
            next_phase_on = 1'b0;
          end
        end
      end
      status_led_pkg::ST_RUN: begin
        if (held || fault_valid) begin
          next_state = status_led_pkg::ST_PAUSE;
          next_after_pause = status_led_pkg::ST_BURST;
          next_timer = PAUSE_T;
        end
      end
      status_led_pkg::ST_PAUSE: begin
        if (timer_done) begin
          next_state = after_pause;
          next_pulses = 5'h00;
          next_phase_on = 1'b1;
          next_timer = (after_pause == status_led_pkg::ST_BURST) ? FAST_T : SLOW_T;
        end
      end
      status_led_pkg::ST_BURST, status_led_pkg::ST_CODE, status_led_pkg::ST_ARG: begin
        if (timer_done) begin
          next_timer = (state == status_led_pkg::ST_BURST) ? FAST_T : SLOW_T;
          next_phase_on = !phase_on;
          if (!phase_on) begin
            next_phase_on = 1'b1;
          end else if (pulses + 5'h01 >= group_len) begin
            next_state = status_led_pkg::ST_PAUSE;
            next_timer = PAUSE_T;
            next_phase_on = 1'b0;
            unique case (state)
              status_led_pkg::ST_BURST: next_after_pause = status_led_pkg::ST_CODE;
              status_led_pkg::ST_CODE: next_after_pause = status_led_pkg::ST_ARG;
              default: next_after_pause = status_led_pkg::ST_BURST;
            endcase
          end else begin
            next_pulses = pulses + 5'h01;
          end
        end
      end
    endcase
    // lamp drive
    next_led_red = 1'b0;
    next_led_green = 1'b0;
    if (next_state == status_led_pkg::ST_RUN) begin
      next_led_green = bus_cycle;
    end else begin
      next_led_red = next_phase_on;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      state <= status_led_pkg::ST_INIT;
      after_pause <= status_led_pkg::ST_BURST;
      timer <= 28'h0000000;
      pulses <= 5'h00;
      phase_on <= 1'b0;
      held <= 1'b0;
      code_q <= 4'h0;
      arg_q <= 4'h0;
      led_red <= 1'b0;
      led_green <= 1'b0;
    end else begin
      state <= next_state;
      after_pause <= next_after_pause;
      timer <= next_timer;
      pulses <= next_pulses;
      phase_on <= next_phase_on;
      held <= next_held;
      code_q <= next_code_q;
      arg_q <= next_arg_q;
      led_red <= next_led_red;
      led_green <= next_led_green;
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  fault_held_a: assert property (@(posedge mclk) disable iff (rst)
    held |=> held && $stable(code_q) && $stable(arg_q))
    else $error("latched fault lost");
  green_run_a: assert property (@(posedge mclk) disable iff (rst)
    (state == status_led_pkg::ST_RUN) && !held && !fault_valid && bus_cycle |=> led_green)
    else $error("green missing while healthy");
  dark_idle_a: assert property (@(posedge mclk) disable iff (rst)
    (state == status_led_pkg::ST_RUN) && !bus_cycle && !held && !fault_valid |=> !led_green && !led_red)
    else $error("lamp lit while idle");
  no_green_fault_a: assert property (@(posedge mclk) disable iff (rst)
    held |=> !led_green)
    else $error("green shown with fault");
  clean_start_a: assert property (@(posedge mclk) disable iff (rst)
    (state == status_led_pkg::ST_INIT) && !init_busy && !held && !fault_valid
      |=> state == status_led_pkg::ST_RUN)
    else $error("clean start not steady");
  pause_dark_a: assert property (@(posedge mclk) disable iff (rst)
    (state == status_led_pkg::ST_PAUSE) |-> !led_green && !led_red && !phase_on)
    else $error("pause not dark");
  arg_to_burst_a: assert property (@(posedge mclk) disable iff (rst)
    (state == status_led_pkg::ST_ARG) && (next_state == status_led_pkg::ST_PAUSE)
      |=> after_pause == status_led_pkg::ST_BURST)
    else $error("message not repeated");
  burst_count_a: assert property (@(posedge mclk) disable iff (rst)
    (state == status_led_pkg::ST_BURST) |-> pulses < BURST_N)
    else $error("burst too long");
  code_count_a: assert property (@(posedge mclk) disable iff (rst)
    (state == status_led_pkg::ST_CODE) && (code_q != 4'h0) |-> pulses < {1'b0, code_q})
    else $error("code pulses exceed code");
  red_follow_a: assert property (@(posedge mclk) disable iff (rst)
    (state == status_led_pkg::ST_INIT) && init_busy |=> led_red == phase_on)
    else $error("init flash not on lamp");

  // ----------------------------------------
  // check helpers
  // ----------------------------------------
  // these watch the red drive itself rather than the sequencer counters,
  // so a miscounted group or a wrong half period cannot hide behind a
  // sequencer that merely agrees with itself
  logic [27:0] red_age, next_red_age;
  logic [4:0] red_rises, next_red_rises;

  always_comb begin
    next_red_age = red_age;
    next_red_rises = red_rises;
    // saturate, since a long dark spell in running must not wrap around
    if (red_age != 28'hFFFFFFF) begin
      next_red_age = red_age + 28'h0000001;
    end
    if (next_led_red != led_red) begin
      next_red_age = 28'h0000000;
    end
    if (next_led_red && !led_red && (red_rises != 5'h1F)) begin
      next_red_rises = red_rises + 5'h01;
    end
    // every pause opens a fresh group
    if (next_state == status_led_pkg::ST_PAUSE) begin
      next_red_rises = 5'h00;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      red_age <= 28'h0000000;
      red_rises <= 5'h00;
    end else begin
      red_age <= next_red_age;
      red_rises <= next_red_rises;
    end
  end

  // ----------------------------------------
  // lamp timing checks
  // ----------------------------------------
  // the first rise of each group is launched from the state before it,
  // so a rise sampled inside a group always follows a full dark half
  init_half_a: assert property (@(posedge mclk) disable iff (rst)
    (state == status_led_pkg::ST_INIT) && init_busy && led_red && !next_led_red
      |-> red_age == FAST_T)
    else $error("start-up flash lit half wrong");
  init_gap_a: assert property (@(posedge mclk) disable iff (rst)
    (state == status_led_pkg::ST_INIT) && init_busy && !led_red && next_led_red &&
      (red_rises != 5'h00) |-> red_age == FAST_T)
    else $error("start-up flash dark half wrong");
  burst_half_a: assert property (@(posedge mclk) disable iff (rst)
    (state == status_led_pkg::ST_BURST) && (led_red != next_led_red) |-> red_age == FAST_T)
    else $error("burst half period wrong");
  slow_half_a: assert property (@(posedge mclk) disable iff (rst)
    ((state == status_led_pkg::ST_CODE) || (state == status_led_pkg::ST_ARG)) &&
      (led_red != next_led_red) |-> red_age == SLOW_T)
    else $error("slow pulse half period wrong");
  // only pauses before the code and argument groups are timed; the one before a burst
  // follows start-up, running or an argument group, and is not timed
  pause_len_a: assert property (@(posedge mclk) disable iff (rst)
    (state == status_led_pkg::ST_PAUSE) && (next_state != status_led_pkg::ST_PAUSE) &&
      (after_pause != status_led_pkg::ST_BURST) |-> red_age == PAUSE_T)
    else $error("pause length wrong");

  // ----------------------------------------
  // group and flow checks
  // ----------------------------------------
  // counts come from the lamp, so a pulse lost in the phase logic is
  // caught even when the sequencer counter reaches its limit
  burst_total_a: assert property (@(posedge mclk) disable iff (rst)
    (state == status_led_pkg::ST_BURST) && (next_state == status_led_pkg::ST_PAUSE)
      |-> red_rises == BURST_N)
    else $error("burst pulse count wrong");
  code_total_a: assert property (@(posedge mclk) disable iff (rst)
    (state == status_led_pkg::ST_CODE) && (next_state == status_led_pkg::ST_PAUSE)
      |-> red_rises == ((code_q == 4'h0) ? 5'h01 : {1'b0, code_q}))
    else $error("code pulse count wrong");
  arg_total_a: assert property (@(posedge mclk) disable iff (rst)
    (state == status_led_pkg::ST_ARG) && (next_state == status_led_pkg::ST_PAUSE)
      |-> red_rises == ((arg_q == 4'h0) ? 5'h01 : {1'b0, arg_q}))
    else $error("argument pulse count wrong");
  run_no_red_a: assert property (@(posedge mclk) disable iff (rst)
    (state == status_led_pkg::ST_RUN) |-> !led_red)
    else $error("red lit after clean start");
  fault_in_run_a: assert property (@(posedge mclk) disable iff (rst)
    (state == status_led_pkg::ST_RUN) && fault_valid
      |=> (state == status_led_pkg::ST_PAUSE) && (after_pause == status_led_pkg::ST_BURST))
    else $error("fault in running not shown");
  latch_value_a: assert property (@(posedge mclk) disable iff (rst)
    fault_valid && !held
      |=> held && (code_q == $past(fault_code)) && (arg_q == $past(fault_arg)))
    else $error("fault values not latched");
endmodule
`default_nettype wire

// ==== rtl/status_led_pkg.sv ====
// constants and types shared by the node status blink coder
package status_led_pkg;
  // timing figures as printed, and the clock rate
  localparam int unsigned CLK_HZ = 125_000_000;
  localparam int unsigned FAST_HZ = 10;
  localparam int unsigned SLOW_HZ = 1;
  localparam int unsigned PAUSE_MS = 1000;
  // half periods in clock cycles, for a fifty percent duty, and the pause length in clock cycles
  localparam int unsigned FAST_HALF = CLK_HZ / (2 * FAST_HZ);
  localparam int unsigned SLOW_HALF = CLK_HZ / (2 * SLOW_HZ);
  localparam int unsigned PAUSE_CYC = (CLK_HZ / 1000) * PAUSE_MS;
  // pulses in the opening burst of every fault message
  localparam int unsigned START_PULSES = 10;
  localparam int unsigned CNT_W = 28;
  localparam int unsigned NUM_W = 4;
  // fault code 1: hardware and configuration group
  localparam logic [3:0] CODE_HW_CONFIG = 4'h1;
  localparam logic [3:0] ARG_INLINE_OVERFLOW = 4'h1;
  localparam logic [3:0] ARG_UNSUPPORTED_TYPE = 4'h2;
  localparam logic [3:0] ARG_PARAM_CHECKSUM = 4'h3;
  localparam logic [3:0] ARG_EEPROM_WRITE = 4'h4;
  localparam logic [3:0] ARG_EEPROM_READ = 4'h5;
  localparam logic [3:0] ARG_CONFIG_AFTER_AUTOMATIC_RESTART = 4'h6;
  localparam logic [3:0] ARG_FIRMWARE_MISMATCH = 4'h7;
  localparam logic [3:0] ARG_EEPROM_TIMEOUT = 4'h8;
  localparam logic [3:0] ARG_INIT_FAULT = 4'h9;
  localparam logic [3:0] ARG_RTC_POWER_FAIL = 4'hA;
  typedef enum logic [5:0] {
    ST_RUN    = 6'b000001,
    ST_INIT   = 6'b000010,
    ST_BURST  = 6'b000100,
    ST_CODE   = 6'b001000,
    ST_ARG    = 6'b010000,
    ST_PAUSE  = 6'b100000
  } blink_state_e;
endpackage

// ==== verification/status_led_blink_coder_tb.sv ====
// self-checking bench for the node status blink coder
`timescale 1ns/1ps
`default_nettype none
module status_led_blink_coder_tb;
  // short counts keep a whole fault message to a few hundred cycles
  localparam int FH = 4;
  localparam int SH = 10;
  localparam int PC = 20;
  logic mclk, rst, bus_cycle, init_busy, fault_valid;
  logic [3:0] fault_code, fault_arg;
  logic led_red, led_green;
  int mismatches = 0;
  int num_checks = 0;

  status_led_blink_coder #(.FAST_HALF(FH), .SLOW_HALF(SH), .PAUSE_CYC(PC))
    status_led_blink_coder_inst (.mclk(mclk), .rst(rst), .bus_cycle(bus_cycle),
    .init_busy(init_busy), .fault_valid(fault_valid), .fault_code(fault_code),
    .fault_arg(fault_arg), .led_red(led_red), .led_green(led_green));

  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic close_out();
    if (mismatches == 0 && num_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic check(string what, int exp, int got);
    num_checks++;
    if (exp != got) begin
      mismatches++;
      $display("mismatch %s expected %0d seen %0d", what, exp, got);
    end
  endtask

  task automatic check_bit(string what, logic exp, logic got);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch %s expected %b seen %b", what, exp, got);
    end
  endtask

  task automatic step();
    @(posedge mclk);
    #1;
  endtask

  // an unknown lamp counts as dark, so it can never pass for a pulse
  task automatic next_run(output int gap, output int on);
    gap = 0;
    on = 0;
    while (led_red !== 1'b1) begin
      check_bit("green dark", 1'b0, led_green);
      gap++;
      bus_cycle = 1'($urandom);
      step();
    end
    while (led_red === 1'b1) begin
      check_bit("green in fault", 1'b0, led_green);
      on++;
      bus_cycle = 1'($urandom);
      step();
    end
  endtask

  function automatic int exp_on(int i);
    return (i < 10) ? FH : SH;
  endfunction

  function automatic int exp_gap(int i, int c);
    if (i == 0 || i == 10 || i == 10 + c)
      return PC;
    return (i < 10) ? FH : SH;
  endfunction

  // zero still shows one pulse
  function automatic int eff(int v);
    return (v == 0) ? 1 : v;
  endfunction

  // syncs on a burst start, then checks one full message and the next opening
  task automatic show_fault(int c, int a);
    int g, o, n;
    n = 10 + c + a;
    do next_run(g, o); while (!(o == FH && g > SH));
    for (int i = 1; i <= n; i++) begin
      next_run(g, o);
      check("pulse length", exp_on(i % n), o);
      check("gap length", exp_gap(i % n, c), g);
    end
  endtask

  task automatic start_fault(logic [3:0] c, logic [3:0] a);
    rst = 1'b1;
    repeat (2) step();
    rst = 1'b0;
    init_busy = 1'b1;
    fault_valid = 1'b1;
    fault_code = c;
    fault_arg = a;
    step();
    // a later fault must not replace the latched one
    fault_code = 4'($urandom);
    fault_arg = 4'($urandom);
    fault_valid = 1'($urandom);
    repeat (5) step();
    init_busy = 1'b0;
    show_fault(eff(c), eff(a));
  endtask

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    int g, o, seed;
    logic b;
    seed = $urandom(32'hC6EA0457);
    rst = 1'b1;
    bus_cycle = 1'b0;
    init_busy = 1'b1;
    fault_valid = 1'b0;
    fault_code = 4'h0;
    fault_arg = 4'h0;
    repeat (8) step();
    rst = 1'b0;
    next_run(g, o);
    next_run(g, o);
    check("init flash on", FH, o);
    check("init flash off", FH, g);
    init_busy = 1'b0;
    repeat (3) step();
    for (int i = 0; i < 40; i++) begin
      b = 1'($urandom);
      bus_cycle = b;
      step();
      check_bit("green run", b, led_green);
      check_bit("red run", 1'b0, led_red);
    end
    bus_cycle = 1'b0;
    step();
    check_bit("green idle", 1'b0, led_green);
    check_bit("red idle", 1'b0, led_red);
    fault_valid = 1'b1;
    fault_code = status_led_pkg::CODE_HW_CONFIG;
    fault_arg = status_led_pkg::ARG_EEPROM_READ;
    step();
    fault_code = 4'h3;
    show_fault(1, 5);
    for (int a = 1; a <= 10; a++)
      start_fault(status_led_pkg::CODE_HW_CONFIG, 4'(a));
    start_fault(4'h0, 4'h0);
    for (int k = 0; k < 3; k++)
      start_fault(4'(1 + $urandom % 3), 4'($urandom % 12));
    close_out();
  end

  initial begin
    // roughly nine to ten times the length of all scenarios together
    repeat (40000) @(posedge mclk);
    mismatches++;
    close_out();
  end
endmodule
`default_nettype wire
